/* bench/eep_slave_tb.sv */
`timescale 1ns/1ns
module eep_slave_tb;
	localparam logic [1:0] DEV = 2'h2;
	localparam int PWR_UP = 20;
	logic strap_hi = 1'h1;
	logic strap_hi_conn = 1'h1;
	logic strap_lo = 1'h1;
	logic strap_lo_conn = 1'h0;
	logic ref_clk_in = 1'h0;
	logic reset_in = 1'h1;
	logic cmd_valid = 1'h0;
	logic cmd_ready;
	eep_pkg::eep_op_t cmd_op = eep_pkg::OP_POLL;
	logic [1:0] cmd_strap = 2'h0;
	logic [16:0] cmd_addr = 17'h0_0000;
	logic [7:0] cmd_len = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wdata_req;
	logic [7:0] rdata;
	logic rdata_valid;
	logic done;
	logic acked;
	logic busy;
	logic wp = 1'h0;
	int error_cnt = 0;
	int checks = 0;
	int s;
	logic [7:0] wq[$];
	logic [7:0] rq[$];

	eep_bus_if bus_if();

	// Strap lo starts floating, so the device answers to 2'h2
	eep_slave #(.PROG_CYCLES(200), .MODULE_PKG(1'h0)) eep_slave_inst (.ref_clk_in(ref_clk_in),
		.reset_in(reset_in), .bus(bus_if.device_mp), .strap_addr_hi_in(strap_hi),
		.strap_addr_hi_conn_in(strap_hi_conn), .strap_addr_lo_in(strap_lo), .strap_addr_lo_conn_in(strap_lo_conn),
		.write_protect_in(wp), .busy_out(busy));
	eep_master #(.QTR_CYCLES(2), .PWR_UP_CYCLES(PWR_UP)) eep_master_inst (.ref_clk_in(ref_clk_in),
		.reset_in(reset_in), .bus(bus_if.master_mp), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
		.cmd_op_in(cmd_op), .cmd_strap_in(cmd_strap), .cmd_addr_in(cmd_addr), .cmd_len_in(cmd_len),
		.wdata_in(wdata), .wdata_req_out(wdata_req), .rdata_out(rdata), .rdata_valid_out(rdata_valid),
		.done_out(done), .acked_out(acked));
	eep_sva eep_sva_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .scl(bus_if.scl),
		.m_sda_out(bus_if.m_sda_out), .m_sda_oe(bus_if.m_sda_oe), .s_sda_out(bus_if.s_sda_out),
		.s_sda_oe(bus_if.s_sda_oe), .sda(bus_if.sda));

	always #50 ref_clk_in = ~ref_clk_in;

	task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask: chk

	task automatic end_sim();
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask: end_sim

	// One master command; write bytes come from wq, read bytes land in rq
	task automatic cmd(input eep_pkg::eep_op_t op, input logic [1:0] st, input logic [16:0] a, input logic [7:0] n);
		int i;
		int k;
		i = 0;
		rq.delete();
		for (k = 0; k < 2000 && cmd_ready !== 1'h1; k++) @(negedge ref_clk_in);
		if (k == 2000) begin
			chk("ready wait", 17'h0_0001, 17'h0_0000);
			end_sim();
		end
		cmd_op = op;
		cmd_strap = st;
		cmd_addr = a;
		cmd_len = n;
		wdata = (wq.size() > 0) ? wq[0] : 8'h00;
		cmd_valid = 1'h1;
		@(negedge ref_clk_in);
		cmd_valid = 1'h0;
		for (k = 0; k < 30000 && done !== 1'h1; k++) begin
			if (wdata_req === 1'h1) begin
				i++;
				wdata = (i < wq.size()) ? wq[i] : 8'h00;
			end
			if (rdata_valid === 1'h1) rq.push_back(rdata);
			@(negedge ref_clk_in);
		end
		if (k == 30000) begin
			chk("done wait", 17'h0_0001, 17'h0_0000);
			end_sim();
		end
	endtask: cmd

	task automatic prog_wait();
		int k;
		for (k = 0; k < 20; k++) begin
			cmd(eep_pkg::OP_POLL, DEV, 17'h0_0000, 8'h00);
			if (acked === 1'h1) break;
		end
		chk("poll after program", 17'h0_0001, {16'h0000, acked});
	endtask: prog_wait

	initial begin
		repeat (8) @(negedge ref_clk_in);
		reset_in = 1'h0;
		for (s = 0; s < 100 && cmd_ready !== 1'h1; s++) @(negedge ref_clk_in);
		chk("power-up wait", 17'(PWR_UP), 17'(s));
		for (s = 0; s < 4; s++) begin
			cmd(eep_pkg::OP_POLL, s[1:0], 17'h0_0000, 8'h00);
			chk("strap ack", {16'h0000, s == 2}, {16'h0000, acked});
		end
		// Connecting the lo strap moves the device to 2'h3
		strap_lo_conn = 1'h1;
		cmd(eep_pkg::OP_POLL, 2'h3, 17'h0_0000, 8'h00);
		chk("strap lo connected", 17'h0_0001, {16'h0000, acked});
		cmd(eep_pkg::OP_POLL, DEV, 17'h0_0000, 8'h00);
		chk("old strap refused", 17'h0_0000, {16'h0000, acked});
		strap_lo_conn = 1'h0;
		// Four bytes from fe cross the page end and wrap to its start
		wq = '{8'h11, 8'h22, 8'h33, 8'h44};
		cmd(eep_pkg::OP_WRITE, DEV, 17'h1_00fe, 8'h03);
		chk("page write ack", 17'h0_0001, {16'h0000, acked});
		for (s = 0; s < 8 && busy !== 1'h1; s++) @(negedge ref_clk_in);
		chk("busy after stop", 17'h0_0001, {16'h0000, busy});
		cmd(eep_pkg::OP_POLL, DEV, 17'h0_0000, 8'h00);
		chk("poll while busy", 17'h0_0000, {16'h0000, acked});
		prog_wait();
		wq = '{8'h66};
		cmd(eep_pkg::OP_WRITE, DEV, 17'h0_0000, 8'h00);
		prog_wait();
		wq = '{8'h55};
		cmd(eep_pkg::OP_WRITE, DEV, 17'h1_ffff, 8'h00);
		prog_wait();
		wq.delete();
		cmd(eep_pkg::OP_RAND_READ, DEV, 17'h1_0000, 8'h01);
		chk("wrapped byte", 17'h0_0033, {9'h000, rq[0]});
		chk("next wrapped", 17'h0_0044, {9'h000, rq[1]});
		cmd(eep_pkg::OP_RAND_READ, DEV, 17'h1_00fe, 8'h00);
		chk("random read", 17'h0_0011, {9'h000, rq[0]});
		cmd(eep_pkg::OP_CUR_READ, DEV, 17'h0_0000, 8'h00);
		chk("current read", 17'h0_0022, {9'h000, rq[0]});
		cmd(eep_pkg::OP_RAND_READ, DEV, 17'h1_ffff, 8'h01);
		chk("last byte", 17'h0_0055, {9'h000, rq[0]});
		chk("array wrap", 17'h0_0066, {9'h000, rq[1]});
		wp = 1'h1;
		wq = '{8'haa};
		cmd(eep_pkg::OP_WRITE, DEV, 17'h1_00fe, 8'h00);
		chk("protected ack", 17'h0_0001, {16'h0000, acked});
		cmd(eep_pkg::OP_POLL, DEV, 17'h0_0000, 8'h00);
		chk("protected poll", 17'h0_0001, {16'h0000, acked});
		wp = 1'h0;
		cmd(eep_pkg::OP_RAND_READ, DEV, 17'h1_00fe, 8'h00);
		chk("protected byte", 17'h0_0011, {9'h000, rq[0]});
		end_sim();
	end
endmodule: eep_slave_tb

/* bench/eep_sva.sv */
`timescale 1ns/1ns
module eep_sva (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic scl,
	input wire logic m_sda_out,
	input wire logic m_sda_oe,
	input wire logic s_sda_out,
	input wire logic s_sda_oe,
	input wire logic sda
);
	logic prev_scl;
	logic prev_sda;
	logic [3:0] bit_cnt;
	logic first_byte;
	logic [7:0] shift;
	logic start_c;
	logic stop_c;
	logic scl_rise;

	assign start_c = prev_scl & scl & prev_sda & ~sda;
	assign stop_c = prev_scl & scl & ~prev_sda & sda;
	assign scl_rise = scl & ~prev_scl;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			prev_scl <= 1'h1;
			prev_sda <= 1'h1;
		end else begin
			prev_scl <= scl;
			prev_sda <= sda;
		end
	end

	// Bit position within the byte, so acks can be told from data bits
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			bit_cnt <= 4'h0;
			first_byte <= 1'h0;
			shift <= 8'h00;
		end else if (start_c) begin
			bit_cnt <= 4'h0;
			first_byte <= 1'h1;
		end else if (scl_rise) begin
			if (bit_cnt == 4'h8) begin
				bit_cnt <= 4'h0;
				first_byte <= 1'h0;
			end else begin
				bit_cnt <= bit_cnt + 4'h1;
				shift <= {shift[6:0], sda};
			end
		end
	end

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	a_reset_bus_idle: assert property ($past(reset_in) |-> scl && !m_sda_oe && !s_sda_oe)
		else $error("bus not idle after reset");
	a_scl_high_time: assert property ($rose(scl) |-> scl [*4])
		else $error("scl high phase too short");
	a_scl_low_time: assert property ($fell(scl) |-> !scl [*4])
		else $error("scl low phase too short");
	a_start_then_clock: assert property (start_c |-> ##[1:4] !scl)
		else $error("scl did not fall after start");
	a_stop_bus_free: assert property (stop_c |-> (scl && !s_sda_oe) [*4])
		else $error("bus not free after stop");
	a_dev_data_stable: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
		else $error("device changed sda while scl high");
	a_dev_word_listen: assert property (scl_rise && first_byte && bit_cnt < 4'h8 |-> !s_sda_oe)
		else $error("device drove sda during device word");
	a_dev_type_ack: assert property (scl_rise && first_byte && bit_cnt == 4'h8 && s_sda_oe
		|-> shift[7:4] == eep_pkg::TYPE_CODE)
		else $error("device acked a foreign type code");

	c_start: cover property (start_c);
	c_stop: cover property (stop_c);
	c_dev_ack: cover property (scl_rise && first_byte && bit_cnt == 4'h8 && s_sda_oe);
	c_dev_read_bit: cover property (scl_rise && !first_byte && bit_cnt < 4'h8 && s_sda_oe);
endmodule: eep_sva

/* core/eep_bus_if.sv */
`timescale 1ns/1ns
interface eep_bus_if;
	logic scl;
	logic m_sda_out;
	logic m_sda_oe;
	logic s_sda_out;
	logic s_sda_oe;
	logic sda;

	// Open-drain data line: any enabled driver showing zero pulls it low
	assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

	modport master_mp (output scl, output m_sda_out, output m_sda_oe, input sda);
	modport device_mp (output s_sda_out, output s_sda_oe, input scl, input sda);
endinterface: eep_bus_if

/* core/eep_master.sv */
`timescale 1ns/1ns
module eep_master #(
	parameter int QTR_CYCLES = eep_pkg::QTR_CYCLES,
	parameter int PWR_UP_CYCLES = eep_pkg::PWR_UP_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	eep_bus_if.master_mp bus,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire eep_pkg::eep_op_t cmd_op_in,
	input wire logic [1:0] cmd_strap_in,
	input wire logic [16:0] cmd_addr_in,
	input wire logic [7:0] cmd_len_in,
	input wire logic [7:0] wdata_in,
	output logic wdata_req_out,
	output logic [7:0] rdata_out,
	output logic rdata_valid_out,
	output logic done_out,
	output logic acked_out
);
	localparam int QW = $clog2(QTR_CYCLES + 1);
	localparam int CW = $clog2(PWR_UP_CYCLES + 1);

	eep_pkg::eep_mst_state_t state;
	eep_pkg::eep_op_t op;
	logic [1:0] strap;
	logic [16:0] addr;
	logic [7:0] remain;
	logic [2:0] step;
	logic [1:0] q;
	logic [QW-1:0] qcnt;
	logic tick;
	logic [3:0] bitidx;
	logic [8:0] tx;
	logic [8:0] rx;
	logic scl;
	logic sda_bit;
	logic [CW-1:0] pwr_cnt;
	logic sda_m1;
	logic sda_s;
	logic wr_byte;
	logic [7:0] dev_word;

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			sda_m1 <= 1'h1;
			sda_s <= 1'h1;
		end else begin
			sda_m1 <= bus.sda;
			sda_s <= sda_m1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in || state == eep_pkg::M_IDLE || tick)
			qcnt <= '0;
		else
			qcnt <= qcnt + QW'(1);
	end

	assign tick = qcnt == QW'(QTR_CYCLES - 1);
	assign wr_byte = step != eep_pkg::STEP_DATA || op == eep_pkg::OP_WRITE;
	assign dev_word = {eep_pkg::TYPE_CODE, strap, addr[16], 1'h0};

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state <= eep_pkg::M_PWR;
			op <= eep_pkg::OP_WRITE;
			strap <= 2'h0;
			addr <= 17'h0_0000;
			remain <= 8'h00;
			step <= eep_pkg::STEP_DEV;
			q <= 2'h0;
			bitidx <= 4'h0;
			tx <= 9'h1ff;
			rx <= 9'h000;
			scl <= 1'h1;
			sda_bit <= 1'h1;
			pwr_cnt <= '0;
			acked_out <= 1'h0;
			done_out <= 1'h0;
			rdata_out <= 8'h00;
			rdata_valid_out <= 1'h0;
			wdata_req_out <= 1'h0;
		end else begin
			done_out <= 1'h0;
			rdata_valid_out <= 1'h0;
			wdata_req_out <= 1'h0;
			unique case (state)
				eep_pkg::M_PWR: begin
					pwr_cnt <= pwr_cnt + CW'(1);
					if (pwr_cnt == CW'(PWR_UP_CYCLES - 1))
						state <= eep_pkg::M_IDLE;
				end
				eep_pkg::M_IDLE: begin
					if (cmd_valid_in) begin
						op <= cmd_op_in;
						strap <= cmd_strap_in;
						addr <= cmd_addr_in;
						remain <= cmd_len_in;
						step <= cmd_op_in == eep_pkg::OP_CUR_READ ? eep_pkg::STEP_DEV_RD : eep_pkg::STEP_DEV;
						q <= 2'h0;
						sda_bit <= 1'h1;
						state <= eep_pkg::M_START;
					end
				end
				eep_pkg::M_START: begin
					if (tick) begin
						q <= q + 2'h1;
						unique case (q)
							2'h0: scl <= 1'h1;
							2'h1: sda_bit <= 1'h0;
							2'h2: scl <= 1'h0;
							2'h3: begin
								tx <= {dev_word[7:1], step == eep_pkg::STEP_DEV_RD, 1'h1};
								sda_bit <= dev_word[7];
								bitidx <= 4'h0;
								state <= eep_pkg::M_BYTE;
							end
						endcase
					end
				end
				eep_pkg::M_BYTE: begin
					if (tick) begin
						q <= q + 2'h1;
						unique case (q)
							2'h0: scl <= 1'h1;
							// Two quarters high, two low: the device sees every rise after its synchroniser
							2'h1: begin
							end
							2'h2: begin
								rx <= {rx[7:0], sda_s};
								scl <= 1'h0;
							end
							2'h3: begin
								if (bitidx != 4'h8) begin
									tx <= {tx[7:0], 1'h1};
									sda_bit <= tx[7];
									bitidx <= bitidx + 4'h1;
								end else begin
									bitidx <= 4'h0;
									if (wr_byte && rx[0]) begin
										// Not acknowledged: device absent or still programming
										acked_out <= 1'h0;
										sda_bit <= 1'h0;
										state <= eep_pkg::M_STOP;
									end else begin
										unique case (step)
											eep_pkg::STEP_DEV: begin
												if (op == eep_pkg::OP_POLL) begin
													acked_out <= 1'h1;
													sda_bit <= 1'h0;
													state <= eep_pkg::M_STOP;
												end else begin
													step <= eep_pkg::STEP_HI;
													tx <= {addr[15:8], 1'h1};
													sda_bit <= addr[15];
												end
											end
											eep_pkg::STEP_HI: begin
												step <= eep_pkg::STEP_LO;
												tx <= {addr[7:0], 1'h1};
												sda_bit <= addr[7];
											end
											eep_pkg::STEP_LO: begin
												if (op == eep_pkg::OP_WRITE) begin
													step <= eep_pkg::STEP_DATA;
													tx <= {wdata_in, 1'h1};
													sda_bit <= wdata_in[7];
													wdata_req_out <= 1'h1;
												end else begin
													// Dummy write done: repeated start then read
													step <= eep_pkg::STEP_DEV_RD;
													sda_bit <= 1'h1;
													state <= eep_pkg::M_START;
												end
											end
											eep_pkg::STEP_DEV_RD: begin
												step <= eep_pkg::STEP_DATA;
												tx <= {8'hff, remain == 8'h00};
												sda_bit <= 1'h1;
											end
											default: begin
												if (op != eep_pkg::OP_WRITE) begin
													rdata_out <= rx[8:1];
													rdata_valid_out <= 1'h1;
												end
												if (remain == 8'h00) begin
													acked_out <= 1'h1;
													sda_bit <= 1'h0;
													state <= eep_pkg::M_STOP;
												end else begin
													remain <= remain - 8'h01;
													if (op == eep_pkg::OP_WRITE) begin
														tx <= {wdata_in, 1'h1};
														sda_bit <= wdata_in[7];
														wdata_req_out <= 1'h1;
													end else begin
														tx <= {8'hff, remain == 8'h01};
														sda_bit <= 1'h1;
													end
												end
											end
										endcase
									end
								end
							end
						endcase
					end
				end
				eep_pkg::M_STOP: begin
					if (tick) begin
						q <= q + 2'h1;
						unique case (q)
							2'h0: scl <= 1'h1;
							2'h1: sda_bit <= 1'h1;
							2'h2: begin
							end
							2'h3: begin
								done_out <= 1'h1;
								state <= eep_pkg::M_IDLE;
							end
						endcase
					end
				end
				default: state <= eep_pkg::M_IDLE;
			endcase
		end
	end

	assign cmd_ready_out = state == eep_pkg::M_IDLE;
	assign bus.scl = scl;
	assign bus.m_sda_out = 1'h0;
	assign bus.m_sda_oe = ~sda_bit;
endmodule: eep_master

/* core/eep_pkg.sv */
package eep_pkg;
	localparam int CLK_NS = 100;
	localparam int ADDR_W = 17;
	localparam logic [3:0] TYPE_CODE = 4'ha;
	// Self-timed programming cycle length
	localparam int PROGRAM_CYCLE_TIME_MS = 5;
	localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_MS * 1_000_000 / CLK_NS;
	// Least wait from power-on to the first command, rounded up
	localparam int PWR_UP_US = 100;
	localparam int PWR_UP_CYCLES = (PWR_UP_US * 1000 + CLK_NS - 1) / CLK_NS;
	// Serial clock made by the master, split into four quarters
	localparam int SCL_PERIOD_NS = 800;
	localparam int QTR_CYCLES = SCL_PERIOD_NS / 4 / CLK_NS;
	// Synchroniser reset values: scl, sda, wp, strap hi, strap lo
	localparam logic [4:0] SYNC_RST = 5'h18;
	// Master byte steps
	localparam logic [2:0] STEP_DEV = 3'h0;
	localparam logic [2:0] STEP_HI = 3'h1;
	localparam logic [2:0] STEP_LO = 3'h2;
	localparam logic [2:0] STEP_DEV_RD = 3'h3;
	localparam logic [2:0] STEP_DATA = 3'h4;

	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_RAND_READ = 2'h1,
		OP_CUR_READ = 2'h2,
		OP_POLL = 2'h3
	} eep_op_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_RECV = 6'h02,
		ST_ACK = 6'h04,
		ST_SEND = 6'h08,
		ST_MACK = 6'h10,
		ST_PROG = 6'h20
	} eep_dev_state_t;

	typedef enum logic [4:0] {
		M_PWR = 5'h01,
		M_IDLE = 5'h02,
		M_START = 5'h04,
		M_BYTE = 5'h08,
		M_STOP = 5'h10
	} eep_mst_state_t;
endpackage: eep_pkg

/* core/eep_slave.sv */
// Contract
// - Device word starts with fixed type pattern
// - Two device bits match the strap inputs
// - Unconnected strap input reads as low
// - Seventh bit is top word address bit
// - Module variant needs three zero bits
// - Eighth bit: one reads, zero writes
// - Match acknowledges low; mismatch returns to standby
// - Write protect high blocks all programming
// - Byte write: device, two address, data, stop
// - Stop after write starts deaf programming cycle
// - Page write accepts up to 256 bytes
// - Write increments low byte, wraps in page
// - Polling acknowledged only after programming ends
// - Address counter keeps last address plus one
// - Reads wrap from last to first byte
// - Current read: ack, byte out, nack, stop
// - Random read: dummy write, restart, read
// - Sequential read continues while master acknowledges
// - Master waits 100 us before first command
// - Start/stop only while clock high
// - Standby at power-up and after stop
`timescale 1ns/1ns
module eep_slave #(
	parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES,
	parameter bit MODULE_PKG = 1'h0
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	eep_bus_if.device_mp bus,
	input wire logic strap_addr_hi_in,
	input wire logic strap_addr_hi_conn_in,
	input wire logic strap_addr_lo_in,
	input wire logic strap_addr_lo_conn_in,
	input wire logic write_protect_in,
	output logic busy_out
);
	localparam int AW = eep_pkg::ADDR_W;
	localparam int PW = $clog2(PROG_CYCLES + 1);

	logic [4:0] pin_raw;
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	eep_pkg::eep_dev_state_t state;
	logic [7:0] shreg;
	logic [3:0] bitcnt;
	logic [1:0] byte_idx;
	logic is_read;
	logic page_select_bit;
	logic [7:0] addr_hi_q;
	logic [AW-1:0] addr;
	logic wr_pending;
	logic sda_oe;
	logic mack;
	logic [PW-1:0] prog_cnt;
	logic prog_done;
	logic dev_match;
	logic byte_in;
	logic [7:0] rd_byte;
	logic [7:0] mem [0:(1 << AW)-1];

	// A floating strap has no connection and is taken as low
	assign pin_raw = {bus.scl, bus.sda, write_protect_in,
		strap_addr_hi_conn_in & strap_addr_hi_in, strap_addr_lo_conn_in & strap_addr_lo_in};

	generate
		for (genvar i = 0; i < 5; i++) begin : g_sync
			always_ff @(posedge ref_clk_in) begin
				if (reset_in) begin
					sync1[i] <= eep_pkg::SYNC_RST[i];
					sync2[i] <= eep_pkg::SYNC_RST[i];
				end else begin
					sync1[i] <= pin_raw[i];
					sync2[i] <= sync1[i];
				end
			end
		end
	endgenerate

	assign scl_s = sync2[4];
	assign sda_s = sync2[3];
	assign wp_s = sync2[2];

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			scl_d <= 1'h1;
			sda_d <= 1'h1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

	always_comb begin
		dev_match = shreg[7:4] == eep_pkg::TYPE_CODE;
		if (MODULE_PKG)
			dev_match = dev_match && shreg[3:1] == 3'h0;
		else
			dev_match = dev_match && shreg[3:2] == sync2[1:0];
	end

	assign byte_in = state == eep_pkg::ST_RECV && scl_fall && bitcnt == 4'h8;
	assign rd_byte = mem[addr];

	// Main protocol engine; the programming cycle ignores the bus entirely
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state <= eep_pkg::ST_IDLE;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			byte_idx <= 2'h0;
			is_read <= 1'h0;
			page_select_bit <= 1'h0;
			addr_hi_q <= 8'h00;
			addr <= '0;
			wr_pending <= 1'h0;
			sda_oe <= 1'h0;
			mack <= 1'h0;
		end else if (state == eep_pkg::ST_PROG) begin
			if (prog_done)
				state <= eep_pkg::ST_IDLE;
		end else if (stop_det) begin
			sda_oe <= 1'h0;
			wr_pending <= 1'h0;
			state <= wr_pending ? eep_pkg::ST_PROG : eep_pkg::ST_IDLE;
		end else if (start_det) begin
			state <= eep_pkg::ST_RECV;
			bitcnt <= 4'h0;
			byte_idx <= 2'h0;
			sda_oe <= 1'h0;
		end else begin
			unique case (state)
				eep_pkg::ST_IDLE: begin
				end
				eep_pkg::ST_RECV: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_s};
						bitcnt <= bitcnt + 4'h1;
					end else if (byte_in) begin
						bitcnt <= 4'h0;
						state <= eep_pkg::ST_ACK;
						sda_oe <= 1'h1;
						unique case (byte_idx)
							2'h0: begin
								if (dev_match) begin
									is_read <= shreg[0];
									page_select_bit <= shreg[1];
									byte_idx <= 2'h1;
								end else begin
									state <= eep_pkg::ST_IDLE;
									sda_oe <= 1'h0;
								end
							end
							2'h1: begin
								addr_hi_q <= shreg;
								byte_idx <= 2'h2;
							end
							2'h2: begin
								addr <= {page_select_bit, addr_hi_q, shreg};
								byte_idx <= 2'h3;
							end
							2'h3: begin
								addr[7:0] <= addr[7:0] + 8'h01;
								wr_pending <= wr_pending | ~wp_s;
							end
						endcase
					end
				end
				eep_pkg::ST_SEND: begin
					if (scl_fall) begin
						if (bitcnt == 4'h7) begin
							sda_oe <= 1'h0;
							state <= eep_pkg::ST_MACK;
						end else begin
							shreg <= {shreg[6:0], 1'h1};
							sda_oe <= ~shreg[6];
							bitcnt <= bitcnt + 4'h1;
						end
					end
				end
				eep_pkg::ST_ACK, eep_pkg::ST_MACK: begin
					if (scl_rise)
						mack <= ~sda_s;
					if (scl_fall) begin
						bitcnt <= 4'h0;
						if (state == eep_pkg::ST_ACK && !is_read) begin
							sda_oe <= 1'h0;
							state <= eep_pkg::ST_RECV;
						end else if (state == eep_pkg::ST_ACK || mack) begin
							// Counter advances over the full array on reads
							shreg <= rd_byte;
							sda_oe <= ~rd_byte[7];
							addr <= addr + 17'h0_0001;
							state <= eep_pkg::ST_SEND;
						end else begin
							sda_oe <= 1'h0;
							state <= eep_pkg::ST_IDLE;
						end
					end
				end
				default: state <= eep_pkg::ST_IDLE;
			endcase
		end
	end

	// Array is written as bytes arrive; protection blocks every location
	always_ff @(posedge ref_clk_in) begin
		if (byte_in && byte_idx == 2'h3 && !wp_s)
			mem[addr] <= shreg;
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in || state != eep_pkg::ST_PROG)
			prog_cnt <= '0;
		else
			prog_cnt <= prog_cnt + PW'(1);
	end

	assign prog_done = prog_cnt == PW'(PROG_CYCLES - 1);
	assign bus.s_sda_out = 1'h0;
	assign bus.s_sda_oe = sda_oe;
	assign busy_out = state == eep_pkg::ST_PROG;
endmodule: eep_slave
